//--- verilog/oacr_pkg.sv
// Functional notes
// (R1) Overlay start address bit 31 reads 1 while a buffer flip is pending.
// (R2) Address registers: bit 27 local/system memory, bit 26 chip select.
// (R3) Address bits 25:4 are 128-bit aligned; bits 3:0 always read zero.
// (R4) Separate overlay end address register with same memory and select bits.
// (R5) Window width 29:20 and line stride 13:4, low four bits zero.
// (R6) Rectangle corners: 11-bit line field 26:16, 11-bit pixel field 10:0.
// (R7) Scaling bit 31 vertical shrink, bit 15 horizontal shrink, reset zero.
// (R8) 12-bit vertical and horizontal factors are fractions scaled by 4096.
// (R9) Initial vertical factor in bits 11:0, upper bits reserved, reset zero.
// (R10) Key match compares value bits only where mask bit is zero.
// (R11) Eight palette words, sixteen 5:6:5 colours, even colour in low half.
// (R12) Pointer image address bit 31 turns the pointer sprite on.
// (R13) Pointer Y and X positions; bits 27 and 11 flag top/left clipping.
// (R14) Pointer colours one and two in one word, colour three next word.
// (R15) Blend control bit 28 picks constant alpha field 27:24 over per-pixel.
// (R16) Fifo request when empty count reaches 1, 3, 7 or 11; reset selects 3.
// (R17) Blend control bits 7:4 give the smooth panning start pixel.
// (R18) Blend control bit 3 enables keying, bit 2 shows the alpha plane. The key compare is gated by overlay control bit 3 instead.
// (R19) Format 01 is 5:6:5, 10 indexed or 4:4, 11 alpha 4:4:4:4.
// (R20) Overlay plane shows only while its control bit 2 is set.
// (R21) Reserved bits ignore writes and read back zero.
// (R22) Software programs undefined registers before enabling; avoids format 00.
package oacr_pkg;

	// ==========================================================
	// bus geometry
	localparam int ADDR_W    = 20;
	localparam int NREG      = 14;
	localparam int PAL_DEPTH = 8;
	localparam int PAL_AW    = 3;

	// ==========================================================
	// register indices
	localparam logic [3:0] IDX_OVL_CTRL  = 4'h0;
	localparam logic [3:0] IDX_OVL_START = 4'h1;
	localparam logic [3:0] IDX_OVL_LINE  = 4'h2;
	localparam logic [3:0] IDX_OVL_END   = 4'h3;
	localparam logic [3:0] IDX_OVL_TL    = 4'h4;
	localparam logic [3:0] IDX_OVL_BR    = 4'h5;
	localparam logic [3:0] IDX_OVL_SCALE = 4'h6;
	localparam logic [3:0] IDX_OVL_INIT  = 4'h7;
	localparam logic [3:0] IDX_OVL_KEY   = 4'h8;
	localparam logic [3:0] IDX_PTR_ADDR  = 4'h9;
	localparam logic [3:0] IDX_PTR_POS   = 4'ha;
	localparam logic [3:0] IDX_PTR_C12   = 4'hb;
	localparam logic [3:0] IDX_PTR_C3    = 4'hc;
	localparam logic [3:0] IDX_BLEND     = 4'hd;

	// ==========================================================
	// byte offsets, in index order
	localparam logic [ADDR_W-1:0] REG_OFS [NREG] = '{
		20'h80080, 20'h80084, 20'h80088, 20'h8008c,
		20'h80090, 20'h80094, 20'h80098, 20'h8009c,
		20'h800a0, 20'h800f0, 20'h800f4, 20'h800f8,
		20'h800fc, 20'h80100};
	localparam logic [ADDR_W-1:0] OFS_PAL_FIRST = 20'h800a4;
	localparam logic [ADDR_W-1:0] OFS_PAL_LAST  = 20'h800c0;

	// writable bits; everything else reads zero except start bit 31, the flip flag
	localparam logic [31:0] REG_MASK [NREG] = '{
		32'h1f030fff, 32'h0ffffff0, 32'h3ff03ff0, 32'h0ffffff0,
		32'h07ff07ff, 32'h07ff07ff, 32'h8fff8fff, 32'h00000fff,
		32'hffffffff, 32'h8ffffff0, 32'h0fff0fff, 32'hffffffff,
		32'h0000ffff, 32'h1f0300ff};

	// reset values (undefined ones are held at zero)
	localparam logic [31:0] REG_RST [NREG] = '{
		32'h00010000, 32'h00000000, 32'h00000000, 32'h00000000,
		32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000,
		32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000,
		32'h00000000, 32'h00010000};

	// ==========================================================
	// field positions
	localparam int BIT_FLIP      = 31;
	localparam int BIT_SYS_MEM   = 27;
	localparam int BIT_CS_SEL    = 26;
	localparam int BIT_PTR_ON    = 31;
	localparam int BIT_PTR_TOP   = 27;
	localparam int BIT_PTR_LEFT  = 11;
	localparam int BIT_CONST_SEL = 28;
	localparam int LSB_ALPHA     = 24;
	localparam int LSB_FIFO      = 16;
	localparam int LSB_PAN       = 4;
	localparam int BIT_KEY_ON    = 3;
	localparam int BIT_PLANE_ON  = 2;
	localparam int LSB_FORMAT    = 0;
	localparam int LSB_KEY_MASK  = 16;

	// empty-entry thresholds for the fifo level field
	localparam logic [3:0] FIFO_LVL_0 = 4'h1;
	localparam logic [3:0] FIFO_LVL_1 = 4'h3;
	localparam logic [3:0] FIFO_LVL_2 = 4'h7;
	localparam logic [3:0] FIFO_LVL_3 = 4'hb;

	localparam logic [1:0] FMT_UNUSED = 2'h0;

endpackage

//--- verilog/oacr_palette_mem.sv
`timescale 1ns/1ps

// two registered read ports: one for the bus, one for the pixel path
module oacr_palette_mem #(
	parameter int DEPTH = 8,
	parameter int AW    = 3
) (
	input  wire logic          sys_clk_in,
	input  wire logic          nrst_in,
	input  wire logic          wr_en_in,
	input  wire logic [AW-1:0] wr_addr_in,
	input  wire logic [31:0]   wr_mask_in,
	input  wire logic [31:0]   wr_data_in,
	input  wire logic [AW-1:0] rd_a_addr_in,
	output logic      [31:0]   rd_a_data_out,
	input  wire logic [AW-1:0] rd_b_addr_in,
	output logic      [31:0]   rd_b_data_out
);

	typedef struct packed {
		logic [DEPTH-1:0][31:0] mem;
		logic [31:0]            rd_a;
		logic [31:0]            rd_b;
	} oacr_mem_s;

	oacr_mem_s st_r;
	oacr_mem_s st_nxt;

	// ==========================================================
	// next state: masked word write, both reads registered
	always_comb begin
		st_nxt = st_r;
		if (wr_en_in) begin
			st_nxt.mem[wr_addr_in] = (st_r.mem[wr_addr_in] & ~wr_mask_in)
				| (wr_data_in & wr_mask_in);
		end
		st_nxt.rd_a = st_r.mem[rd_a_addr_in];
		st_nxt.rd_b = st_r.mem[rd_b_addr_in];
	end

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rd_a_data_out = st_r.rd_a;
	assign rd_b_data_out = st_r.rd_b;

endmodule // oacr_palette_mem

//--- verilog/oacr_regs.sv
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps

module oacr_regs (
	input  wire logic                        sys_clk_in,
	input  wire logic                        nrst_in,
	// apb slave
	input  wire logic                        psel_in,
	input  wire logic                        penable_in,
	input  wire logic                        pwrite_in,
	input  wire logic [oacr_pkg::ADDR_W-1:0] paddr_in,
	input  wire logic [31:0]                 pwdata_in,
	input  wire logic [3:0]                  pstrb_in,
	output logic      [31:0]                 prdata_out,
	output logic                             pready_out,
	output logic                             pslverr_out,
	// display side events and samples
	input  wire logic                        flip_done_in,
	input  wire logic [15:0]                 key_pixel_in,
	input  wire logic [3:0]                  pixel_alpha_in,
	input  wire logic [3:0]                  blend_fifo_empty_in,
	input  wire logic [3:0]                  lookup_index_in,
	// register words for the fetch and blend datapath
	output logic      [31:0]                 overlay_control_out,
	output logic      [31:0]                 overlay_start_out,
	output logic      [31:0]                 overlay_line_out,
	output logic      [31:0]                 overlay_end_out,
	output logic      [31:0]                 overlay_top_left_out,
	output logic      [31:0]                 overlay_bottom_right_out,
	output logic      [31:0]                 overlay_scaling_out,
	output logic      [31:0]                 overlay_initial_out,
	output logic      [31:0]                 pointer_address_out,
	output logic      [31:0]                 pointer_position_out,
	output logic      [31:0]                 pointer_colours_out,
	output logic      [31:0]                 pointer_colour_three_out,
	output logic      [31:0]                 blend_control_out,
	// decoded controls
	output logic                             overlay_enable_out,
	output logic                             pointer_sprite_on_out,
	output logic                             pointer_top_clip_out,
	output logic                             pointer_left_clip_out,
	output logic                             blend_enable_out,
	output logic                             blend_key_on_out,
	output logic      [1:0]                  blend_format_out,
	output logic                             blend_format_valid_out,
	output logic      [3:0]                  blend_pan_out,
	output logic      [3:0]                  blend_alpha_out,
	output logic                             blend_fifo_request_out,
	output logic                             key_hit_out,
	output logic      [15:0]                 lookup_colour_out
);

	import oacr_pkg::*;

	typedef struct packed {
		logic [NREG-1:0][31:0] regs;
		logic                  flip_pend;
		logic [31:0]           rd;
		logic                  rd_pal;
		logic                  key_hit;
		logic                  fifo_req;
		logic [3:0]            alpha;
		logic                  lut_odd;
	} oacr_state_s;

	oacr_state_s st_r;
	oacr_state_s st_nxt;

	logic [4:0]        reg_find;
	logic              reg_hit;
	logic [3:0]        reg_idx;
	logic              pal_hit;
	logic [ADDR_W-1:0] pal_off;
	logic [PAL_AW-1:0] pal_idx;
	logic              setup_ph;
	logic              access_ph;
	logic              wr_fire;
	logic [31:0]       strobe_mask;
	logic [31:0]       wr_mask;
	logic [31:0]       read_word;
	logic [31:0]       pal_rd;
	logic [31:0]       lut_rd;
	logic [3:0]        fifo_level;

	// ==========================================================
	// address decode
	// ==========================================================

	// plain table search; unaligned addresses never match
	function automatic logic [4:0] find_reg(
		input logic [ADDR_W-1:0] a
	);
		logic [4:0] r;
		r = 5'h00;
		for (int i = 0; i < NREG; i++) begin
			if (a == REG_OFS[i]) begin
				r = {1'b1, 4'(i)};
			end
		end
		return r;
	endfunction

	// byte lanes expand to a bit mask
	function automatic logic [31:0] lanes(input logic [3:0] s);
		logic [31:0] m;
		m = 32'h00000000;
		for (int b = 0; b < 4; b++) begin
			m[8*b +: 8] = {8{s[b]}};
		end
		return m;
	endfunction

	assign reg_find = find_reg(paddr_in);
	assign reg_hit  = reg_find[4];
	assign reg_idx  = reg_find[3:0];
	assign pal_off  = paddr_in - OFS_PAL_FIRST;
	assign pal_idx  = pal_off[PAL_AW+1:2];

	// palette words sit between the key and pointer registers
	always_comb begin
		if (paddr_in[1:0] != 2'h0) begin
			pal_hit = 1'b0;
		end else if (paddr_in < OFS_PAL_FIRST) begin
			pal_hit = 1'b0;
		end else if (paddr_in > OFS_PAL_LAST) begin
			pal_hit = 1'b0;
		end else begin
			pal_hit = 1'b1; // [R11]
		end
	end

	// ==========================================================
	// bus phases
	// ==========================================================

	// no wait states: the palette read port is launched in setup,
	// so its registered word is ready by the access phase
	assign setup_ph    = psel_in & ~penable_in;
	assign access_ph   = psel_in & penable_in;
	assign wr_fire     = access_ph & pwrite_in;
	assign strobe_mask = lanes(pstrb_in);
	assign wr_mask     = strobe_mask & REG_MASK[reg_idx]; // [R21]

	// read value; the flip flag is not stored in the word itself
	always_comb begin
		read_word = st_r.regs[reg_idx];
		if (reg_idx == IDX_OVL_START) begin
			read_word[BIT_FLIP] = st_r.flip_pend; // [R1]
		end
		if (!reg_hit) begin
			read_word = 32'h00000000;
		end
	end

	// fifo threshold from the blend level field
	always_comb begin
		case (st_r.regs[IDX_BLEND][LSB_FIFO +: 2])
			2'h0: fifo_level = FIFO_LVL_0; // [R16]
			2'h1: fifo_level = FIFO_LVL_1; // [R16]
			2'h2: fifo_level = FIFO_LVL_2; // [R16]
			default: fifo_level = FIFO_LVL_3; // [R16]
		endcase
	end

	// ==========================================================
	// palette storage
	// ==========================================================

	oacr_palette_mem #(
		.DEPTH (PAL_DEPTH),
		.AW    (PAL_AW)
	) u_palette (
		.sys_clk_in    (sys_clk_in),
		.nrst_in       (nrst_in),
		.wr_en_in      (wr_fire & pal_hit),
		.wr_addr_in    (pal_idx),
		.wr_mask_in    (strobe_mask),
		.wr_data_in    (pwdata_in),
		.rd_a_addr_in  (pal_idx),
		.rd_a_data_out (pal_rd),
		.rd_b_addr_in  (lookup_index_in[3:1]), // [R11]
		.rd_b_data_out (lut_rd)
	);

	// ==========================================================
	// next state
	// ==========================================================

	always_comb begin
		st_nxt = st_r;

		// masked write; reserved and hardwired bits stay zero
		if (wr_fire && reg_hit) begin
			st_nxt.regs[reg_idx] = (st_r.regs[reg_idx] & ~wr_mask)
				| (pwdata_in & wr_mask); // [R2] [R3] [R21]
		end

		// a new start address arms a flip; display clears it.
		// the write wins so a same-cycle flip never loses it
		if (wr_fire && reg_hit && reg_idx == IDX_OVL_START) begin
			st_nxt.flip_pend = 1'b1; // [R1]
		end else if (flip_done_in) begin
			st_nxt.flip_pend = 1'b0; // [R1]
		end

		// capture read data during setup so prdata comes from flops
		if (setup_ph) begin
			st_nxt.rd     = read_word;
			st_nxt.rd_pal = pal_hit;
		end

		// masked key compare only while overlay control bit 3 is set
		st_nxt.key_hit = st_r.regs[IDX_OVL_CTRL][BIT_KEY_ON]
			& (((key_pixel_in ^ st_r.regs[IDX_OVL_KEY][15:0])
			& ~st_r.regs[IDX_OVL_KEY][LSB_KEY_MASK +: 16])
			== 16'h0000); // [R10]

		// fifo refill request once enough entries are empty
		st_nxt.fifo_req = (blend_fifo_empty_in >= fifo_level); // [R16]

		// constant alpha replaces per-pixel alpha when selected
		if (st_r.regs[IDX_BLEND][BIT_CONST_SEL]) begin
			st_nxt.alpha = st_r.regs[IDX_BLEND][LSB_ALPHA +: 4]; // [R15]
		end else begin
			st_nxt.alpha = pixel_alpha_in; // [R15]
		end

		// remember which half of the palette word to pick
		st_nxt.lut_odd = lookup_index_in[0]; // [R11]
	end

	// ==========================================================
	// state register
	// ==========================================================

	always_ff @(posedge sys_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			for (int i = 0; i < NREG; i++) begin
				st_r.regs[i] <= REG_RST[i]; // [R7] [R9] [R16]
			end
			st_r.flip_pend <= 1'b0;
			st_r.rd        <= 32'h00000000;
			st_r.rd_pal    <= 1'b0;
			st_r.key_hit   <= 1'b0;
			st_r.fifo_req  <= 1'b0;
			st_r.alpha     <= 4'h0;
			st_r.lut_odd   <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ==========================================================
	// bus answers
	// ==========================================================

	assign pready_out  = 1'b1;
	assign pslverr_out = access_ph & ~(reg_hit | pal_hit);
	assign prdata_out  = st_r.rd_pal ? pal_rd : st_r.rd;

	// ==========================================================
	// register words to the datapath
	// ==========================================================

	// address words carry memory select and chip select in 27:26
	assign overlay_control_out = st_r.regs[IDX_OVL_CTRL];
	assign overlay_start_out = {st_r.flip_pend,
		st_r.regs[IDX_OVL_START][30:0]}; // [R1] [R2] [R3]
	assign overlay_line_out = st_r.regs[IDX_OVL_LINE]; // [R5]
	assign overlay_end_out = st_r.regs[IDX_OVL_END]; // [R4]
	assign overlay_top_left_out = st_r.regs[IDX_OVL_TL]; // [R6]
	assign overlay_bottom_right_out = st_r.regs[IDX_OVL_BR]; // [R6]
	// factors are x/4096 fractions; the scaler does the stepping
	assign overlay_scaling_out = st_r.regs[IDX_OVL_SCALE]; // [R7] [R8]
	assign overlay_initial_out = st_r.regs[IDX_OVL_INIT]; // [R9]
	assign pointer_address_out = st_r.regs[IDX_PTR_ADDR]; // [R12]
	assign pointer_position_out = st_r.regs[IDX_PTR_POS]; // [R13]
	assign pointer_colours_out = st_r.regs[IDX_PTR_C12]; // [R14]
	assign pointer_colour_three_out = st_r.regs[IDX_PTR_C3]; // [R14]
	assign blend_control_out = st_r.regs[IDX_BLEND];

	// ==========================================================
	// decoded controls
	// ==========================================================

	// the overlay plane is blanked whenever its enable is clear
	assign overlay_enable_out =
		st_r.regs[IDX_OVL_CTRL][BIT_PLANE_ON]; // [R20]
	assign pointer_sprite_on_out =
		st_r.regs[IDX_PTR_ADDR][BIT_PTR_ON]; // [R12]
	assign pointer_top_clip_out =
		st_r.regs[IDX_PTR_POS][BIT_PTR_TOP]; // [R13]
	assign pointer_left_clip_out =
		st_r.regs[IDX_PTR_POS][BIT_PTR_LEFT]; // [R13]
	assign blend_enable_out =
		st_r.regs[IDX_BLEND][BIT_PLANE_ON]; // [R18]
	assign blend_key_on_out =
		st_r.regs[IDX_BLEND][BIT_KEY_ON]; // [R18]
	assign blend_format_out =
		st_r.regs[IDX_BLEND][LSB_FORMAT +: 2]; // [R19]
	// code 00 is not a defined alpha format; flag it to the fetch
	assign blend_format_valid_out =
		(st_r.regs[IDX_BLEND][LSB_FORMAT +: 2] != FMT_UNUSED); // [R19]
	assign blend_pan_out =
		st_r.regs[IDX_BLEND][LSB_PAN +: 4]; // [R17]
	assign blend_alpha_out        = st_r.alpha;
	assign blend_fifo_request_out = st_r.fifo_req;
	assign key_hit_out            = st_r.key_hit;

	// even index in the low half, odd in the high half
	assign lookup_colour_out = st_r.lut_odd ? lut_rd[31:16]
		: lut_rd[15:0]; // [R11]

endmodule // oacr_regs

//--- tb/oacr_regs_sva.sv
`timescale 1ns/1ps

// ==========================================================
// port checker for the register bank
module oacr_regs_sva
	import oacr_pkg::*;
(
	input wire logic                        sys_clk_in,
	input wire logic                        nrst_in,
	input wire logic                        psel_in,
	input wire logic                        penable_in,
	input wire logic                        pwrite_in,
	input wire logic [oacr_pkg::ADDR_W-1:0] paddr_in,
	input wire logic [31:0]                 pwdata_in,
	input wire logic [3:0]                  pstrb_in,
	input wire logic                        pready_out,
	input wire logic                        pslverr_out,
	input wire logic                        flip_done_in,
	input wire logic [3:0]                  pixel_alpha_in,
	input wire logic [3:0]                  blend_fifo_empty_in,
	input wire logic                        key_hit_out,
	input wire logic [31:0]                 overlay_control_out,
	input wire logic [31:0]                 overlay_start_out,
	input wire logic [31:0]                 overlay_end_out,
	input wire logic [31:0]                 overlay_initial_out,
	input wire logic [31:0]                 overlay_scaling_out,
	input wire logic [31:0]                 pointer_address_out,
	input wire logic                        pointer_sprite_on_out,
	input wire logic [31:0]                 blend_control_out,
	input wire logic [3:0]                  blend_alpha_out,
	input wire logic                        blend_fifo_request_out,
	input wire logic                        overlay_enable_out,
	input wire logic                        blend_key_on_out,
	input wire logic                        blend_format_valid_out
);
	logic [3:0] lvl_thr;
	logic       fifo_hit;
	logic [3:0] alpha_want;

	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!nrst_in);

	// empty-entry threshold picked by the level field
	always_comb begin
		case (blend_control_out[17:16])
			2'h0: lvl_thr = 4'h1;
			2'h1: lvl_thr = 4'h3;
			2'h2: lvl_thr = 4'h7;
			default: lvl_thr = 4'hb;
		endcase
	end

	// expected datapath results, one cycle ahead
	assign fifo_hit   = blend_fifo_empty_in >= lvl_thr;
	assign alpha_want = blend_control_out[28] ? blend_control_out[27:24]
		: pixel_alpha_in;

	// ==========================================================
	// bus phases
	sequence acc_s;
		psel_in && penable_in;
	endsequence
	sequence flip_wr_s;
		acc_s ##0 (pwrite_in && paddr_in == 20'h80084);
	endsequence

	ready_in_access_a: assert property (acc_s |-> pready_out)
		else $error("pready low in access");
	bad_addr_err_a: assert property (acc_s ##0 (paddr_in[1:0] != 2'h0)
		|-> pslverr_out) else $error("no error on unaligned access");
	scale_write_a: assert property (acc_s ##0 (pwrite_in && pstrb_in == 4'hf
		&& paddr_in == 20'h80098) |=> overlay_scaling_out ==
		($past(pwdata_in) & 32'h8fff8fff)) else $error("scale");
	flip_arm_a: assert property (flip_wr_s |=> overlay_start_out[31])
		else $error("flip not pending after write");
	flip_clear_a: assert property (flip_done_in && !(psel_in && penable_in
		&& pwrite_in && paddr_in == 20'h80084) |=> !overlay_start_out[31])
		else $error("flip still pending");
	fifo_level_a: assert property (1'b1 |=> blend_fifo_request_out ==
		$past(fifo_hit)) else $error("fifo request level");
	alpha_pick_a: assert property (1'b1 |=> blend_alpha_out ==
		$past(alpha_want)) else $error("alpha source");
	key_needs_on_a: assert property (key_hit_out |->
		$past(overlay_control_out[3])) else $error("key hit while off");
	low_bits_zero_a: assert property (overlay_start_out[3:0] == 4'h0 &&
		overlay_end_out[3:0] == 4'h0 && pointer_address_out[3:0] == 4'h0 &&
		overlay_initial_out[31:12] == 20'h0)
		else $error("hardwired bits set");
	decode_match_a: assert property (overlay_enable_out ==
		overlay_control_out[2] && pointer_sprite_on_out ==
		pointer_address_out[31] && blend_key_on_out == blend_control_out[3]
		&& blend_format_valid_out == (blend_control_out[1:0] != 2'h0))
		else $error("decoded control");
endmodule // oacr_regs_sva

//--- tb/oacr_regs_bench.sv
`timescale 1ns/1ps

module oacr_regs_bench;
	import oacr_pkg::*;
	logic              sys_clk_in, nrst_in, psel_in, penable_in, pwrite_in;
	logic [ADDR_W-1:0] paddr_in;
	logic [31:0]       pwdata_in, prdata_out, overlay_start_out;
	logic [3:0]        pstrb_in, pixel_alpha_in, blend_fifo_empty_in;
	logic [3:0]        lookup_index_in, blend_pan_out, blend_alpha_out;
	logic [15:0]       key_pixel_in, lookup_colour_out;
	logic [1:0]        blend_format_out;
	logic              pready_out, pslverr_out, flip_done_in, key_hit_out;
	logic              overlay_enable_out, pointer_sprite_on_out;
	logic              pointer_top_clip_out, pointer_left_clip_out;
	logic              blend_enable_out, blend_key_on_out;
	logic              blend_format_valid_out, blend_fifo_request_out;
	int                n_mismatch, total_checks;

	oacr_regs DUT (.sys_clk_in, .nrst_in, .psel_in, .penable_in, .pwrite_in,
		.paddr_in, .pwdata_in, .pstrb_in, .prdata_out, .pready_out,
		.pslverr_out, .flip_done_in, .key_pixel_in, .pixel_alpha_in,
		.blend_fifo_empty_in, .lookup_index_in, .overlay_control_out(),
		.overlay_start_out, .overlay_line_out(), .overlay_end_out(),
		.overlay_top_left_out(), .overlay_bottom_right_out(),
		.overlay_scaling_out(), .overlay_initial_out(),
		.pointer_address_out(), .pointer_position_out(),
		.pointer_colours_out(), .pointer_colour_three_out(),
		.blend_control_out(), .overlay_enable_out, .pointer_sprite_on_out,
		.pointer_top_clip_out, .pointer_left_clip_out, .blend_enable_out,
		.blend_key_on_out, .blend_format_out, .blend_format_valid_out,
		.blend_pan_out, .blend_alpha_out, .blend_fifo_request_out,
		.key_hit_out, .lookup_colour_out);

	// ==========================================================
	// clock, verdict and comparison
	initial begin
		sys_clk_in = 1'b0;
		forever #12.5 sys_clk_in = ~sys_clk_in;
	end

	task automatic stop_test();
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	// ==========================================================
	// bus master; slave answer is awaited, never assumed
	task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
		input logic [31:0] d, output logic [31:0] rd, output logic err);
		int n;
		@(posedge sys_clk_in);
		psel_in <= 1'b1;
		pwrite_in <= wr;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge sys_clk_in);
		penable_in <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk_in);
			n++;
			if (n > 16) begin
				n_mismatch++;
				stop_test();
			end
		end while (pready_out !== 1'b1);
		rd = prdata_out;
		err = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask

	// registered datapath outputs are looked at mid-cycle
	task automatic settle();
		@(posedge sys_clk_in);
		@(negedge sys_clk_in);
	endtask

	// ==========================================================
	// scenarios
	task automatic t_regs();
		logic [31:0] r, x;
		logic        e;
		for (int i = 0; i < NREG; i++) begin
			apb(1'b0, REG_OFS[i], 32'h0, r, e);
			check(r, REG_RST[i]);
		end
		check({31'h0, blend_format_valid_out}, 32'h0);
		// all ones shows every writable bit; blend word first, overlay control last
		for (int i = NREG - 1; i >= 0; i--) begin
			wr(REG_OFS[i], 32'hffffffff);
			apb(1'b0, REG_OFS[i], 32'h0, r, e);
			x = REG_MASK[i];
			if (i == IDX_OVL_START) x[31] = 1'b1;
			check(r, x);
		end
		@(posedge sys_clk_in);
		flip_done_in <= 1'b1;
		@(posedge sys_clk_in);
		flip_done_in <= 1'b0;
		apb(1'b0, REG_OFS[IDX_OVL_START], 32'h0, r, e);
		check(r, 32'h0ffffff0);
		apb(1'b0, 20'h800c4, 32'h0, r, e);
		check(r, 32'h0);
		check({31'h0, e}, 32'h1);
		apb(1'b1, 20'h80082, 32'h0, r, e);
		check({31'h0, e}, 32'h1);
		// byte lanes: only lane 1 of the key word is cleared
		pstrb_in <= 4'h2;
		wr(REG_OFS[IDX_OVL_KEY], 32'h0);
		pstrb_in <= 4'hf;
		apb(1'b0, REG_OFS[IDX_OVL_KEY], 32'h0, r, e);
		check(r, 32'hffff00ff);
	endtask

	task automatic t_palette();
		logic [31:0] r;
		logic        e;
		for (int k = 0; k < PAL_DEPTH; k++) begin
			wr(ADDR_W'(OFS_PAL_FIRST + 4 * k),
				{16'(16'h0a01 + 2 * k), 16'(16'h0a00 + 2 * k)});
		end
		apb(1'b0, OFS_PAL_LAST, 32'h0, r, e);
		check(r, 32'h0a0f0a0e);
		for (int i = 0; i < 16; i++) begin
			@(posedge sys_clk_in);
			lookup_index_in <= 4'(i);
			settle();
			check({16'h0, lookup_colour_out}, 32'(16'h0a00 + i));
		end
	endtask

	task automatic t_blend();
		logic [3:0] thr [4] = '{4'h1, 4'h3, 4'h7, 4'hb};
		for (int l = 0; l < 4; l++) begin
			wr(20'h80100, {14'h0, 2'(l), 16'h1}); // format 01
			@(posedge sys_clk_in);
			blend_fifo_empty_in <= thr[l] - 4'h1;
			settle();
			check({31'h0, blend_fifo_request_out}, 32'h0);
			@(posedge sys_clk_in);
			blend_fifo_empty_in <= thr[l];
			settle();
			check({31'h0, blend_fifo_request_out}, 32'h1);
		end
		wr(20'h80100, 32'h1a0000ab);
		settle();
		check({19'h0, blend_alpha_out, blend_pan_out, blend_key_on_out,
			blend_enable_out, blend_format_out, blend_format_valid_out},
			{19'h0, 4'ha, 4'ha, 2'b10, 2'h3, 1'b1});
		for (int f = 1; f < 4; f++) begin // code 00 never written
			wr(20'h80100, 32'(4 + f));
			settle();
			check({24'h0, blend_alpha_out, blend_enable_out, blend_format_out,
				blend_format_valid_out},
				{24'h0, 4'h5, 1'b1, 2'(f), f != 0});
		end
	endtask

	task automatic t_key();
		wr(REG_OFS[IDX_OVL_KEY], 32'h00ff1234);
		wr(REG_OFS[IDX_OVL_CTRL], 32'h0001000c);
		@(posedge sys_clk_in);
		key_pixel_in <= 16'h12ab;
		settle();
		check({30'h0, key_hit_out, overlay_enable_out}, 32'h3);
		@(posedge sys_clk_in);
		key_pixel_in <= 16'h13ab;
		settle();
		check({31'h0, key_hit_out}, 32'h0);
		wr(REG_OFS[IDX_OVL_CTRL], 32'h00010000);
		@(posedge sys_clk_in);
		key_pixel_in <= 16'h1234;
		settle();
		check({30'h0, key_hit_out, overlay_enable_out}, 32'h0);
		wr(REG_OFS[IDX_PTR_ADDR], 32'h80000000);
		wr(REG_OFS[IDX_PTR_POS], 32'h00000800);
		@(negedge sys_clk_in);
		check({29'h0, pointer_sprite_on_out, pointer_top_clip_out,
			pointer_left_clip_out}, 32'h5);
	endtask

	// reset, then each scenario in turn
	initial begin
		nrst_in = 1'b0;
		psel_in = 1'b0;
		penable_in = 1'b0;
		pwrite_in = 1'b0;
		paddr_in = '0;
		pwdata_in = '0;
		pstrb_in = 4'hf;
		flip_done_in = 1'b0;
		key_pixel_in = '0;
		pixel_alpha_in = 4'h5;
		blend_fifo_empty_in = '0;
		lookup_index_in = '0;
		n_mismatch = 0;
		total_checks = 0;
		repeat (2) @(posedge sys_clk_in);
		nrst_in <= 1'b1;
		t_regs();
		t_palette();
		t_blend();
		t_key();
		stop_test();
	end
endmodule // oacr_regs_bench

bind oacr_regs oacr_regs_sva u_sva (.sys_clk_in, .nrst_in, .psel_in,
	.penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pstrb_in, .pready_out,
	.pslverr_out, .flip_done_in, .pixel_alpha_in, .blend_fifo_empty_in,
	.key_hit_out, .overlay_control_out, .overlay_start_out, .overlay_end_out,
	.overlay_initial_out, .overlay_scaling_out, .pointer_address_out,
	.pointer_sprite_on_out, .blend_control_out, .blend_alpha_out,
	.blend_fifo_request_out, .overlay_enable_out, .blend_key_on_out,
	.blend_format_valid_out);
